// ### design/acs_cmd_status_top.sv
`timescale 1ns/10ps
module acs_cmd_status_top import acs_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic sync_n_i,
    input wire logic conv_done_i,
    input wire logic [DATA_W-1:0] conv_word_i,
    input wire logic [3:0] conv_chan_i,
    input wire logic conv_start_i,
    input wire logic cal_start_i,
    input wire logic idle_entry_i,
    input wire logic cal_mode_i,
    input wire logic coef_wr_i,
    input wire logic cont_mode_i,
    input wire logic err_any_i,
    output logic rdy_n_o,
    output logic sdo_o,
    output logic sdo_oe_o
);

    // ------------------------------------------------------------
    // Core state, all on the master clock
    // ------------------------------------------------------------
    typedef struct packed {
        logic rdy_n; // Active-low ready flag
        logic por; // Power-on event flag
        logic main_err; // Summary error
        logic [3:0] chan; // Channel of held result
        logic [DATA_W-1:0] data; // Result register
        logic unread; // Result written, not yet read
        logic pend; // Result waiting out its warning lead
        logic [DATA_W-1:0] pend_word; // Waiting result
        logic [3:0] pend_chan; // Channel of waiting result
        logic [2:0] warn_cnt; // Cycles left before the write
        acs_snap_t snap; // Frozen copy the link reads
        logic sync_prev; // Last synchronised sync level
        logic stat_prev; // Last status-read toggle
        logic data_prev; // Last result-read toggle
    } acs_core_t;

    acs_core_t s_r; // Core state
    acs_core_t s_nxt; // Next core state
    acs_link_evt_t link_evt; // Link events, link clock
    acs_snap_t snap; // Snapshot offered to the link
    logic [4:0] xs_q; // Synchronised link events and sync pin
    acs_link_evt_t evt_s; // Synchronised link events
    logic sync_s; // Synchronised sync pin
    logic stat_rd_ev; // One-cycle pulse: status read finished
    logic data_rd_ev; // One-cycle pulse: result read finished
    logic sync_fall; // One-cycle pulse: sync pin taken low
    logic wr_now; // Warning lead expired this cycle
    logic wr_done; // Result actually written this cycle
    acs_status_t stat_now; // Live status byte

    // ------------------------------------------------------------
    // Serial link, on the host's clock
    // ------------------------------------------------------------
    acs_serial_link u_link (
        .sclk_i(sclk_i),
        .srst_i(srst_i),
        .cs_n_i(cs_n_i),
        .sdi_i(sdi_i),
        .snap_i(snap),
        .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o),
        .evt_o(link_evt)
    );

    // ------------------------------------------------------------
    // Crossings into the master clock
    // ------------------------------------------------------------
    // Levels and toggles only: each bit is safe to sample alone.
    acs_sync2 #(.W(5)) u_evt_sync (
        .clk_i(ref_clk_i),
        .d_i({link_evt, sync_n_i}),
        .q_o(xs_q)
    );

    assign evt_s = acs_link_evt_t'(xs_q[4:1]);
    assign sync_s = xs_q[0];
    assign snap = s_r.snap;

    // Edge detection on synchronised copies only
    always_comb begin
        stat_rd_ev = evt_s.stat_tgl ^ s_r.stat_prev;
        data_rd_ev = evt_s.data_tgl ^ s_r.data_prev;
        sync_fall = s_r.sync_prev & ~sync_s;
        wr_now = s_r.pend & (s_r.warn_cnt == 3'd1) & ~conv_done_i;
        wr_done = wr_now & ~evt_s.data_busy;
        stat_now = '{result_ready_n_flag: s_r.rdy_n, main_err: s_r.main_err, rsvd: 1'b0,
            por: s_r.por, result_channel_index: s_r.chan};
    end

    // ------------------------------------------------------------
    // Ready flag, status and result register
    // ------------------------------------------------------------
    // Order below matters: flag sets to 1 come first and the
    // hardware clears to 0 come last, so a new result is never
    // masked by a read finishing in the same cycle.
    always_comb begin
        s_nxt = s_r;
        s_nxt.stat_prev = evt_s.stat_tgl;
        s_nxt.data_prev = evt_s.data_tgl;
        s_nxt.sync_prev = sync_s;

        // Summary error tracks the error inputs directly
        s_nxt.main_err = err_any_i; // [RL15]

        // Reading status retires the power-on event
        if (stat_rd_ev) begin
            s_nxt.por = 1'b0; // [RL16]
        end

        // New result: park it and start the warning lead
        if (conv_done_i) begin
            s_nxt.pend = 1'b1;
            s_nxt.pend_word = conv_word_i;
            s_nxt.pend_chan = conv_chan_i;
            s_nxt.warn_cnt = WARN_MCLK_CYC;
            s_nxt.rdy_n = 1'b1; // [RL12] [RL14]
        end else if (s_r.pend) begin
            s_nxt.warn_cnt = s_r.warn_cnt - 3'd1;
        end

        // Mode changes and starts announce that no data is ready
        if (idle_entry_i || cal_start_i || conv_start_i) begin
            s_nxt.rdy_n = 1'b1; // [RL10]
        end
        // In continuous mode each conversion start raises the flag
        if (cont_mode_i && conv_start_i) begin
            s_nxt.rdy_n = 1'b1; // [RL14]
        end

        // A finished result read releases the flag
        if (data_rd_ev) begin
            s_nxt.rdy_n = 1'b1; // [RL9]
            s_nxt.unread = 1'b0;
        end

        // Sync taken low while the last result sits unread
        if (sync_fall && s_r.unread) begin
            s_nxt.rdy_n = 1'b1; // [RL11]
        end

        // Lead expired: write, unless the link is shifting the result out
        if (wr_now) begin
            s_nxt.pend = 1'b0;
            // A write under readout is dropped whole; the flag stays up [RL13]
            if (wr_done) begin
                s_nxt.data = s_r.pend_word;
                s_nxt.chan = s_r.pend_chan; // [RL17]
                s_nxt.unread = 1'b1;
                s_nxt.rdy_n = 1'b0; // [RL8]
            end
        end

        // Calibration writing its coefficients also marks ready
        if (cal_mode_i && coef_wr_i) begin
            s_nxt.rdy_n = 1'b0; // [RL8]
        end

        // Snapshot frozen while a transaction runs. The link raises
        // busy seven serial bits before it loads the payload, far more
        // than the two-cycle crossing, so the word is stable when read.
        if (!evt_s.busy) begin
            s_nxt.snap.status = stat_now; // [RL6]
            s_nxt.snap.data = s_r.data;
        end

        // Reset stands in for the power-on event
        if (srst_i) begin
            s_nxt = '0;
            s_nxt.rdy_n = STATUS_RST[ST_RDY_BIT];
            s_nxt.main_err = STATUS_RST[ST_ERR_BIT];
            s_nxt.por = STATUS_RST[ST_POR_BIT]; // [RL16]
            s_nxt.chan = STATUS_RST[ST_CHAN_LSB +: 4];
            s_nxt.snap.status = acs_status_t'(STATUS_RST); // [RL6]
            s_nxt.sync_prev = 1'b1;
        end
    end

    // Register the whole core state
    always_ff @(posedge ref_clk_i) begin
        s_r <= s_nxt;
    end

    // Ready pin is the flag itself, straight from its flip-flop
    assign rdy_n_o = s_r.rdy_n; // [RL7]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    sequence lead_s;
        rdy_n_o && $past(rdy_n_o, 1) && $past(rdy_n_o, 2) && $past(rdy_n_o, 3);
    endsequence

    a_pin_mirror: assert property ( // [RL7]
        !evt_s.busy |=> s_r.snap.status.result_ready_n_flag == $past(rdy_n_o))
        else $error("status ready bit and pin disagree");
    a_warn_lead: assert property ( // [RL12]
        (wr_done && !cal_mode_i) |-> lead_s)
        else $error("flag not high for four clocks before result write");
    a_result_clear: assert property ( // [RL8]
        (wr_done && !idle_entry_i) |=> !rdy_n_o && s_r.data == $past(s_r.pend_word))
        else $error("result write did not clear the flag");
    a_read_release: assert property ( // [RL9]
        (data_rd_ev && !wr_done && !(cal_mode_i && coef_wr_i)) |=> rdy_n_o && !s_r.unread)
        else $error("result read did not release the flag");
    a_start_sets: assert property ( // [RL10]
        ((idle_entry_i || cal_start_i) && !wr_done && !(cal_mode_i && coef_wr_i))
        |=> rdy_n_o)
        else $error("mode change or start did not set the flag");
    a_sync_sets: assert property ( // [RL11]
        (sync_fall && s_r.unread && !wr_done && !(cal_mode_i && coef_wr_i)) |=> rdy_n_o)
        else $error("sync low with unread result did not set the flag");
    a_drop_busy: assert property ( // [RL13]
        (wr_now && evt_s.data_busy) |=> s_r.data == $past(s_r.data) && !s_r.pend)
        else $error("result written during readout");
    // Checked both ways, so an error that goes away must also clear the bit
    a_err_mirror: assert property ( // [RL15]
        !evt_s.busy |=> s_r.main_err == $past(err_any_i)
            && s_r.snap.status.main_err == $past(s_r.main_err))
        else $error("summary error did not follow error inputs");
    a_por_clear: assert property ( // [RL16]
        stat_rd_ev |=> !s_r.por)
        else $error("status read did not clear power-on flag");
    a_chan_load: assert property ( // [RL17]
        wr_done |=> s_r.chan == $past(s_r.pend_chan))
        else $error("channel field did not follow written result");

endmodule

// ### design/acs_pkg.sv
// Notes on behaviour
// RL1: Every transaction opens with command byte; resets 0x10.
// RL2: Gate bit 1 holds position, shifts nothing.
// RL3: After gate 0, load next seven bits.
// RL4: Direction bit 6: 0 write, 1 read.
// RL5: Bits 5:0 select the accessed register.
// RL6: Read-only status at address 0x00, resets 0x10.
// RL7: Ready pin follows active-low ready flag.
// RL8: Result write or calibration coefficient write clears flag.
// RL9: Data read sets flag; coefficient reads do not.
// RL10: Idle, standby, calibration or conversion start set flag.
// RL11: Sync low with unread result sets flag.
// RL12: Flag set four clocks before result write.
// RL13: Result arriving during data readout is dropped.
// RL14: Flag set in continuous conversion mode.
// RL15: Summary error bit mirrors any error present.
// RL16: Power-on bit set at reset, cleared by status read.
// RL17: Channel field names channel of held result.
// RL18: Register bytes follow, then await next command.
// RL19: Shift in on rising serial clock, MSB first.
package acs_pkg;

    // ------------------------------------------------------------
    // Addresses and reset values
    // ------------------------------------------------------------
    localparam logic [5:0] STATUS_ADDR = 6'h00; // Status register select
    localparam logic [5:0] DATA_ADDR = 6'h02; // Result register select
    localparam logic [7:0] CMD_RST = 8'h10; // Command register after reset
    localparam logic [7:0] STATUS_RST = 8'h10; // Status register after reset

    // ------------------------------------------------------------
    // Field positions and counts
    // ------------------------------------------------------------
    localparam int CMD_GATE_BIT = 7; // Gate bit of the command byte
    localparam int CMD_DIR_BIT = 6; // Direction bit of the command byte
    localparam int ST_RDY_BIT = 7; // Ready flag within status
    localparam int ST_ERR_BIT = 6; // Summary error within status
    localparam int ST_POR_BIT = 4; // Power-on flag within status
    localparam int ST_CHAN_LSB = 0; // Channel field base within status
    localparam int DATA_W = 16; // Result width
    localparam logic [4:0] CMD_TAIL_CNT = 5'd6; // Seven command bits, counted down
    localparam logic [4:0] BYTE_BITS = 5'd7; // One byte of payload, counted down
    localparam logic [4:0] WORD_BITS = 5'd15; // Two bytes of payload, counted down
    localparam logic [2:0] WARN_MCLK_CYC = 3'd4; // Lead of flag before result write

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic gate; // Must be 0 to open a transaction
        logic rd; // 1 read, 0 write
        logic [5:0] target_register_select; // Register select
    } acs_cmd_t;

    typedef struct packed {
        logic result_ready_n_flag; // Active-low data ready
        logic main_err; // Any error present
        logic rsvd; // Reads zero
        logic por; // Power-on event seen
        logic [3:0] result_channel_index; // Channel of held result
    } acs_status_t;

    typedef struct packed {
        acs_status_t status; // Frozen status for readout
        logic [DATA_W-1:0] data; // Frozen result for readout
    } acs_snap_t;

    typedef struct packed {
        logic busy; // Transaction in progress
        logic data_busy; // Result register being shifted out
        logic stat_tgl; // Toggles on each finished status read
        logic data_tgl; // Toggles on each finished result read
    } acs_link_evt_t;

    typedef enum logic [2:0] {
        LK_GATE = 3'b001,
        LK_CMD = 3'b010,
        LK_XFER = 3'b100
    } acs_link_st_t;

    typedef struct packed {
        acs_link_st_t st; // Link phase
        logic [4:0] cnt; // Bits left in phase after the current one
        acs_cmd_t cmd; // Transaction command register
        logic [15:0] shreg; // Payload shifter
        logic sdo_oe; // Driving serial out
        acs_link_evt_t evt; // Events toward the core
    } acs_link_t;

    localparam acs_link_t LINK_RST = '{st: LK_GATE, cnt: 5'h00, cmd: acs_cmd_t'(CMD_RST),
        shreg: 16'h0000, sdo_oe: 1'b0, evt: 4'h0};

endpackage

// ### design/acs_serial_link.sv
`timescale 1ns/10ps
module acs_serial_link import acs_pkg::*; (
    input wire logic sclk_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire acs_snap_t snap_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output acs_link_evt_t evt_o
);

    // ------------------------------------------------------------
    // Link-side state
    // ------------------------------------------------------------
    acs_link_t s_r; // Link state
    acs_link_t s_nxt; // Next link state
    acs_cmd_t cmd_nxt; // Command with the current bit shifted in
    logic rst_lk; // Reset carried into the link clock

    // Reset only takes effect once the host clocks the link
    acs_sync2 #(.W(1)) u_rst_sync (
        .clk_i(sclk_i),
        .d_i(srst_i),
        .q_o(rst_lk)
    );

    // ------------------------------------------------------------
    // Frame sequencer, rising edge, MSB first
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        cmd_nxt = acs_cmd_t'({s_r.cmd[6:0], sdi_i});
        case (s_r.st)
            LK_GATE: begin
                // A 1 here leaves us parked on the gate position [RL2]
                if (!cs_n_i && !sdi_i) begin
                    s_nxt.st = LK_CMD; // [RL1]
                    s_nxt.cnt = CMD_TAIL_CNT;
                    s_nxt.cmd = acs_cmd_t'(8'h00);
                    s_nxt.evt.busy = 1'b1;
                end
            end
            LK_CMD: begin
                if (!cs_n_i) begin
                    s_nxt.cmd = cmd_nxt; // [RL3] [RL19]
                    s_nxt.cnt = s_r.cnt - 5'd1;
                    if (s_r.cnt == 5'd0) begin
                        s_nxt.st = LK_XFER;
                        s_nxt.sdo_oe = cmd_nxt.rd; // [RL4]
                        // Width and content follow the selected register [RL5]
                        if (cmd_nxt.target_register_select == DATA_ADDR) begin
                            s_nxt.cnt = WORD_BITS;
                            s_nxt.shreg = snap_i.data;
                            s_nxt.evt.data_busy = cmd_nxt.rd;
                        end else if (cmd_nxt.target_register_select == STATUS_ADDR) begin
                            s_nxt.cnt = BYTE_BITS;
                            s_nxt.shreg = {snap_i.status, 8'h00}; // [RL6]
                        end else begin
                            s_nxt.cnt = BYTE_BITS;
                            s_nxt.shreg = 16'h0000;
                        end
                    end
                end
            end
            LK_XFER: begin
                if (!cs_n_i) begin
                    // Write payload is shifted in and discarded: nothing here is writable
                    s_nxt.shreg = {s_r.shreg[14:0], sdi_i};
                    s_nxt.cnt = s_r.cnt - 5'd1;
                    if (s_r.cnt == 5'd0) begin
                        s_nxt.st = LK_GATE; // [RL18]
                        s_nxt.sdo_oe = 1'b0;
                        s_nxt.evt.busy = 1'b0;
                        s_nxt.evt.data_busy = 1'b0;
                        if (s_r.cmd.rd && s_r.cmd.target_register_select == STATUS_ADDR) begin
                            s_nxt.evt.stat_tgl = ~s_r.evt.stat_tgl;
                        end
                        if (s_r.cmd.rd && s_r.cmd.target_register_select == DATA_ADDR) begin
                            s_nxt.evt.data_tgl = ~s_r.evt.data_tgl; // [RL9]
                        end
                    end
                end
            end
            default: s_nxt.st = LK_GATE;
        endcase
        if (rst_lk) begin
            s_nxt = LINK_RST;
        end
    end

    // Register the whole link state
    always_ff @(posedge sclk_i) begin
        s_r <= s_nxt;
    end

    assign sdo_o = s_r.shreg[15];
    assign sdo_oe_o = s_r.sdo_oe;
    assign evt_o = s_r.evt;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sclk_i); endclocking
    default disable iff (rst_lk);

    sequence cmd_bits_s;
        (s_r.st == LK_CMD && !cs_n_i)[*7];
    endsequence

    a_gate_hold: assert property ( // [RL2]
        (s_r.st == LK_GATE && !cs_n_i && sdi_i) |=> s_r.st == LK_GATE)
        else $error("gate bit 1 did not hold the link");
    a_cmd_load: assert property ( // [RL3]
        cmd_bits_s |=> s_r.st == LK_XFER && s_r.cmd.gate == 1'b0)
        else $error("seven command bits did not load");
    a_dir_read: assert property ( // [RL4]
        (s_r.st == LK_XFER) |-> s_r.sdo_oe == s_r.cmd.rd)
        else $error("output enable disagrees with direction bit");
    a_end_gate: assert property ( // [RL18]
        (s_r.st == LK_XFER && !cs_n_i && s_r.cnt == 5'd0) |=> s_r.st == LK_GATE && !sdo_oe_o)
        else $error("link did not return to await a command");

endmodule

// ### design/acs_sync2.sv
`timescale 1ns/10ps
module acs_sync2 import acs_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ------------------------------------------------------------
    // Two-stage level synchroniser
    // ------------------------------------------------------------
    // Stage 0 may go metastable, so only stage 1 reads it.
    logic [1:0][W-1:0] stage_r; // Synchroniser stages
    logic [1:0][W-1:0] stage_nxt; // Next stage values

    // Shift the level one stage per edge
    always_comb begin
        stage_nxt = {stage_r[0], d_i};
    end

    // Register both stages; no reset, the chain flushes in two edges
    always_ff @(posedge clk_i) begin
        stage_r <= stage_nxt;
    end

    assign q_o = stage_r[1];

endmodule

// ### verification/acs_host_model.sv
`timescale 1ns/10ps
// Host on the serial link; sclk runs only while it sends
module acs_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i
);
    // ------------------------------------------------------------
    // Bit engine
    // ------------------------------------------------------------
    logic [15:0] got_w; // Word shifted back, MSB first
    logic [15:0] oe_w; // Output enable seen at each payload sample
    event got; // Raised as a read frame ends
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b1;
    end
    // Data moves while sclk is low; sdo is taken before the rise
    task automatic bit1(input logic b);
        sdi_o = b;
        #24 got_w = {got_w[14:0], sdo_i};
        oe_w = {oe_w[14:0], sdo_oe_i};
        sclk_o = 1'b1;
        #24 sclk_o = 1'b0;
    endtask
    // Pulses with select high; sdi toggles so no stale level lingers
    task automatic idle(input int n);
        repeat (n) bit1(~sdi_o);
    endtask
    // Gate ones, gate zero, direction, select, then payload
    task automatic xfer(input int g, input logic rd, input logic [5:0] a, input int n);
        cs_n_o = 1'b0;
        repeat (g) bit1(1'b1);
        bit1(1'b0);
        bit1(rd);
        for (int i = 5; i >= 0; i--) bit1(a[i]);
        got_w = 16'h0000;
        oe_w = 16'h0000;
        repeat (n) bit1(~sdi_o);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        if (rd) -> got;
    endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/10ps
module tb_top import acs_pkg::*; ;
    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    logic ref_clk, srst, sync_n, cal_mode, cont_mode, err_any;
    logic [4:0] pl; // Pulses: done, start, cal, idle, coef
    logic [15:0] word, w;
    logic [3:0] chan;
    logic [31:0] seed, r;
    wire sclk, cs_n, sdi;
    logic rdy_n, sdo, sdo_oe;
    logic sdo_line; // Serial out as the host sees it; inverted while released
    logic [15:0] expq[$]; // Expected read words, oldest first
    int mismatches, checks;
    acs_cmd_status_top i_acs_cmd_status_top (.ref_clk_i(ref_clk), .srst_i(srst), .sclk_i(sclk),
        .cs_n_i(cs_n), .sdi_i(sdi), .sync_n_i(sync_n), .conv_done_i(pl[0]), .conv_word_i(word),
        .conv_chan_i(chan), .conv_start_i(pl[1]), .cal_start_i(pl[2]), .idle_entry_i(pl[3]),
        .cal_mode_i(cal_mode), .coef_wr_i(pl[4]), .cont_mode_i(cont_mode), .err_any_i(err_any),
        .rdy_n_o(rdy_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe));
    // A released line shows the inverse, so a late sample reads wrong
    assign sdo_line = sdo_oe ? sdo : ~sdo;
    acs_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line),
        .sdo_oe_i(sdo_oe));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp_w(input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value read word exp %h got %h", e, s);
        end
    endtask
    task automatic cmp_oe(input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value sdo_oe_o exp %h got %h", e, s);
        end
    endtask
    task automatic cmp_f(input logic e);
        checks++;
        if (rdy_n !== e) begin
            mismatches++;
            $display("wrong value rdy_n_o exp %b got %b", e, rdy_n);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // One-cycle event pulse, launched on a falling edge
    task automatic pulse(input logic [4:0] m);
        @(negedge ref_clk) pl = m;
        @(negedge ref_clk) pl = 5'h00;
    endtask
    // Note the word, then read; the gap lets the read's side effects land
    task automatic rd(input int g, input logic [5:0] a, input int n, input logic [15:0] e);
        expq.push_back(e);
        i_host.xfer(g, 1'b1, a, n);
        cmp_oe(16'((32'h1 << n) - 32'h1), i_host.oe_w);
        cyc(4);
    endtask
    // Bounded wait for the flag; running out shows up as a mismatch
    task automatic wait_f(input logic e);
        int k;
        k = 0;
        while (k < 20 && rdy_n !== e) begin
            cyc(1);
            k++;
        end
        cmp_f(e);
    endtask
    // Random result; flag up for the lead, then the flag must equal e once the write is due
    task automatic new_res(input logic e);
        r = xs();
        word = r[15:0];
        chan = r[19:16];
        pulse(5'h01);
        repeat (4) begin
            cmp_f(1'b1);
            cyc(1);
        end
        cmp_f(e);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Second process: each finished read takes the oldest note
    initial forever begin
        @(i_host.got);
        cmp_w(expq.pop_front(), i_host.got_w);
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {srst, sync_n, cal_mode, cont_mode, err_any} = 5'h18;
        pl = 5'h00;
        word = 16'h0000;
        chan = 4'h0;
        seed = 32'heb42b443;
        mismatches = 0;
        checks = 0;
        // Link reset needs sclk edges, so reset is held past ten cycles
        fork
            i_host.idle(3);
        join_none
        cyc(13);
        srst = 1'b0;
        cyc(3);
        i_host.idle(4);
        cmp_f(1'b0);
        rd(2, STATUS_ADDR, 8, {8'h00, STATUS_RST});
        rd(0, STATUS_ADDR, 8, 16'h0000);
        i_host.xfer(0, 1'b0, STATUS_ADDR, 8);
        cmp_oe(16'h0000, i_host.oe_w);
        cyc(4);
        rd(0, 6'h15, 8, 16'h0000);
        err_any = 1'b1;
        new_res(1'b0);
        rd(0, STATUS_ADDR, 8, {12'h004, chan});
        rd(0, DATA_ADDR, 16, word);
        wait_f(1'b1);
        // Errors go away here; the summary bit must follow them down
        {cont_mode, err_any} = 2'h2;
        for (int k = 1; k < 4; k++) begin
            new_res(1'b0);
            pulse(5'h01 << k);
            cmp_f(1'b1);
        end
        pulse(5'h10);
        cmp_f(1'b1);
        cal_mode = 1'b1;
        pulse(5'h10);
        cmp_f(1'b0);
        cal_mode = 1'b0;
        sync_n = 1'b0;
        wait_f(1'b1);
        sync_n = 1'b1;
        w = word;
        // A result lands mid-readout: it is lost and the held word stays
        fork
            rd(0, DATA_ADDR, 16, w);
            begin
                cyc(60);
                new_res(1'b1);
            end
        join
        rd(0, DATA_ADDR, 16, w);
        stop_test();
    end
endmodule
